// ===== rtl/elsr_record.sv
/*
  Error location syndrome record with its selected-record register view,
  the spare register and the pseudo-fault countdown and control registers.
  Assumes capture events and register accesses arrive on i_clk.
*/
// Summary of operation
// (R1) Index field holds failing set index
// (R2) Level-2 data index masked by cache size
// (R3) Queue errors record entry, top eight zero
// (R4) Level-2 array codes tag, data, queue, slave
// (R5) Level-1 data array codes three tags, data
// (R6) Instruction array codes; data array preferred
// (R7) Unit field one-hot detecting unit code
// (R8) Reset clears upper thirty-two syndrome bits
// (R9) Selector zero exposes record through view
// (R10) Spare register reads zero, ignores writes
// (R11) Countdown injects an enabled error kind
// (R12) Countdown enable loads and starts counter
// (R13) Unit, array, index updated in one cycle
`default_nettype none

module elsr_record #(
  parameter int L2_SIZE_LOG2 = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Error capture
  input wire logic i_err_valid,
  input wire elsr_pkg::elsr_src_e i_err_src,
  input wire logic [1:0] i_err_array,
  input wire logic [2:0] i_err_l1i_fail,
  input wire logic [12:0] i_err_index,
  // System register access
  input wire logic i_sreg_rd,
  input wire logic i_sreg_wr,
  input wire elsr_pkg::elsr_id_e i_sreg_id,
  input wire logic [63:0] i_sreg_wdata,
  output logic [63:0] o_sreg_rdata,
  output logic o_sreg_rvalid,
  // Fault injection
  output logic o_inject,
  output elsr_pkg::elsr_inj_e o_inject_kind,
  output logic o_countdown_running
);

  typedef struct packed {
    logic [15:0] selector;
    logic [63:0] syndrome;
    logic [31:0] cdn;
    logic [31:0] ctl;
    logic [63:0] rdata;
    logic rvalid;
  } elsr_state_s;

  elsr_state_s st_reg;
  elsr_state_s st_next;
  logic [12:0] l2_data_mask;
  logic [12:0] loc_index;
  logic [1:0] loc_array;
  logic [3:0] loc_unit;
  logic view_on;
  logic ctl_wr;
  logic [31:0] ctl_wdata;
  logic [31:0] cnt_value;

  ////////////////////////////////////////////////////////////////////////////
  // Index bits kept for level-2 data errors
  genvar b;
  generate
    for (b = 0; b < elsr_pkg::IDX_W; b++) begin : g_mask
      assign l2_data_mask[b] = (b <= L2_SIZE_LOG2 + 2); // R2
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Location fields formatted per detecting unit
  always_comb begin
    loc_index = i_err_index; // R1
    loc_array = i_err_array;
    loc_unit = elsr_pkg::UNIT_L2;
    case (i_err_src)
      elsr_pkg::ELSR_SRC_L1I: begin
        loc_unit = elsr_pkg::UNIT_L1I; // R7
        // Data array reported first when several fail together
        if (i_err_l1i_fail[elsr_pkg::L1I_FAIL_DATA]) begin
          loc_array = elsr_pkg::L1I_ARR_DATA; // R6
        end else if (i_err_l1i_fail[elsr_pkg::L1I_FAIL_TAG]) begin
          loc_array = elsr_pkg::L1I_ARR_TAG; // R6
        end else begin
          loc_array = elsr_pkg::L1I_ARR_MOP; // R6
        end
      end
      elsr_pkg::ELSR_SRC_L1D: begin
        loc_unit = elsr_pkg::UNIT_L1D; // R7
        loc_array = i_err_array; // R5
      end
      elsr_pkg::ELSR_SRC_L2: begin
        loc_unit = elsr_pkg::UNIT_L2; // R7
        loc_array = i_err_array; // R4
        case (i_err_array)
          elsr_pkg::L2_ARR_DATA: loc_index = i_err_index & l2_data_mask; // R2
          elsr_pkg::L2_ARR_TQ: begin
            loc_index = {{elsr_pkg::TQ_UNUSED_BITS{1'b0}},
                         i_err_index[elsr_pkg::IDX_W-elsr_pkg::TQ_UNUSED_BITS-1:0]}; // R3
          end
          elsr_pkg::L2_ARR_CHI: loc_index = 13'h0000; // R1
          default: loc_index = i_err_index;
        endcase
      end
      default: begin
        loc_unit = elsr_pkg::UNIT_L2;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access and capture
  assign view_on = (st_reg.selector == elsr_pkg::SEL_THIS_RECORD); // R9
  assign ctl_wr = i_sreg_wr && view_on && (i_sreg_id == elsr_pkg::ELSR_ID_CTL_VIEW);
  assign ctl_wdata = i_sreg_wdata[31:0] & elsr_pkg::CTL_WMASK;

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = i_sreg_rd;
    if (i_sreg_wr) begin
      case (i_sreg_id)
        elsr_pkg::ELSR_ID_SELECTOR: st_next.selector = i_sreg_wdata[15:0];
        elsr_pkg::ELSR_ID_SYN_VIEW: begin
          if (view_on) begin
            st_next.syndrome = i_sreg_wdata; // R9
          end
        end
        elsr_pkg::ELSR_ID_CDN_VIEW: begin
          if (view_on) begin
            st_next.cdn = i_sreg_wdata[31:0];
          end
        end
        elsr_pkg::ELSR_ID_CTL_VIEW: begin
          if (view_on) begin
            st_next.ctl = ctl_wdata;
          end
        end
        default: st_next.selector = st_reg.selector; // R10
      endcase
    end
    // Capture beats a same-cycle software write on the location fields
    if (i_err_valid) begin
      st_next.syndrome[elsr_pkg::IDX_MSB:elsr_pkg::IDX_LSB] = loc_index; // R13
      st_next.syndrome[elsr_pkg::ARR_MSB:elsr_pkg::ARR_LSB] = loc_array; // R13
      st_next.syndrome[elsr_pkg::UNIT_MSB:elsr_pkg::UNIT_LSB] = loc_unit; // R13
    end
    if (i_sreg_rd) begin
      st_next.rdata = 64'h0000_0000_0000_0000; // R10
      case (i_sreg_id)
        elsr_pkg::ELSR_ID_SELECTOR: st_next.rdata = {48'h0, st_reg.selector};
        elsr_pkg::ELSR_ID_SYN_VIEW: begin
          if (view_on) begin
            st_next.rdata = st_reg.syndrome; // R9
          end
        end
        elsr_pkg::ELSR_ID_CDN_VIEW: begin
          if (view_on) begin
            st_next.rdata = {32'h0, st_reg.cdn};
          end
        end
        elsr_pkg::ELSR_ID_CTL_VIEW: begin
          if (view_on) begin
            st_next.rdata = {32'h0, st_reg.ctl};
          end
        end
        default: st_next.rdata = 64'h0000_0000_0000_0000; // R10
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg.selector <= elsr_pkg::SEL_RESET;
      // Low half is undefined after reset; zero is one legal value
      st_reg.syndrome <= elsr_pkg::SYN_RESET; // R8
      st_reg.cdn <= elsr_pkg::CDN_RESET;
      st_reg.ctl <= elsr_pkg::CTL_RESET;
      st_reg.rdata <= 64'h0000_0000_0000_0000;
      st_reg.rvalid <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error generation counter
  // Countdown value written in the same cycle is taken for the reload at zero
  assign cnt_value = (i_sreg_wr && view_on && (i_sreg_id == elsr_pkg::ELSR_ID_CDN_VIEW)) ?
                     i_sreg_wdata[31:0] : st_reg.cdn;

  elsr_countdown #(
    .CNT_W(32)
  ) u_countdown (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_load(ctl_wr && ctl_wdata[elsr_pkg::CTL_COUNTDOWN_ENABLE]), // R12
    .i_stop(ctl_wr && !ctl_wdata[elsr_pkg::CTL_COUNTDOWN_ENABLE]),
    .i_value(cnt_value),
    .i_restart(st_reg.ctl[elsr_pkg::CTL_RESTART]),
    .i_ctl(st_reg.ctl), // R11
    .o_inject(o_inject),
    .o_kind(o_inject_kind),
    .o_running(o_countdown_running),
    .o_count()
  );

  assign o_sreg_rdata = st_reg.rdata;
  assign o_sreg_rvalid = st_reg.rvalid;

endmodule

`default_nettype wire

// ===== rtl/elsr_pkg.sv
/*
  Constants for the error location syndrome record: field positions, source
  and unit codes, register identifiers, reset values and fault control bits.
  Assumes it is compiled before every other file of the block.
*/
`default_nettype none

package elsr_pkg;

  // Location field positions in the syndrome register
  localparam int IDX_LSB = 6;
  localparam int IDX_MSB = 18;
  localparam int IDX_W = 13;
  localparam int ARR_LSB = 4;
  localparam int ARR_MSB = 5;
  localparam int UNIT_LSB = 0;
  localparam int UNIT_MSB = 3;
  localparam int HI_LSB = 32;
  localparam int TQ_UNUSED_BITS = 8;

  // Unit codes, one-hot
  localparam logic [3:0] UNIT_L1I = 4'h1;
  localparam logic [3:0] UNIT_L1D = 4'h4;
  localparam logic [3:0] UNIT_L2 = 4'h8;

  // Array codes per unit
  localparam logic [1:0] L2_ARR_TAG = 2'h0;
  localparam logic [1:0] L2_ARR_DATA = 2'h1;
  localparam logic [1:0] L2_ARR_TQ = 2'h2;
  localparam logic [1:0] L2_ARR_CHI = 2'h3;
  localparam logic [1:0] L1D_ARR_TAG0 = 2'h0;
  localparam logic [1:0] L1D_ARR_TAG1 = 2'h1;
  localparam logic [1:0] L1D_ARR_DATA = 2'h2;
  localparam logic [1:0] L1D_ARR_TAG2 = 2'h3;
  localparam logic [1:0] L1I_ARR_TAG = 2'h0;
  localparam logic [1:0] L1I_ARR_DATA = 2'h1;
  localparam logic [1:0] L1I_ARR_MOP = 2'h2;

  // Failing-array flags for the instruction side, one bit per array
  localparam int L1I_FAIL_TAG = 0;
  localparam int L1I_FAIL_DATA = 1;
  localparam int L1I_FAIL_MOP = 2;

  // Detecting unit as presented on the capture port
  typedef enum logic [1:0] {
    ELSR_SRC_L1I,
    ELSR_SRC_L1D,
    ELSR_SRC_L2
  } elsr_src_e;

  // System register identifiers
  typedef enum logic [2:0] {
    ELSR_ID_SELECTOR,
    ELSR_ID_SYN_VIEW,
    ELSR_ID_SPARE_VIEW,
    ELSR_ID_CDN_VIEW,
    ELSR_ID_CTL_VIEW
  } elsr_id_e;

  localparam int SEL_W = 16;
  localparam logic [15:0] SEL_THIS_RECORD = 16'h0000;

  // Reset values
  localparam logic [63:0] SYN_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CDN_RESET = 32'h0000_0000;
  localparam logic [15:0] SEL_RESET = 16'h0000;

  // Fault control bits
  localparam int CTL_COUNTDOWN_ENABLE = 31;
  localparam int CTL_RESTART = 30;
  localparam int CTL_UC = 1;
  localparam int CTL_UEU = 2;
  localparam int CTL_UER = 3;
  localparam int CTL_UEO = 4;
  localparam int CTL_DE = 5;
  localparam int CTL_CE_LSB = 6;
  localparam logic [31:0] CTL_WMASK = 32'hc000_1fff;

  // Injected error kind
  typedef enum logic [2:0] {
    ELSR_INJ_NONE,
    ELSR_INJ_UC,
    ELSR_INJ_UEU,
    ELSR_INJ_UER,
    ELSR_INJ_UEO,
    ELSR_INJ_DE,
    ELSR_INJ_CE
  } elsr_inj_e;

endpackage

`default_nettype wire

// ===== rtl/elsr_countdown.sv
/*
  Error generation counter: loads the countdown value, counts down and fires
  one injection of an enabled error kind at zero, then reloads or stops.
  Assumes load and stop come from the register logic on the same clock.
*/
`default_nettype none

module elsr_countdown #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_load,
  input wire logic i_stop,
  input wire logic [CNT_W-1:0] i_value,
  input wire logic i_restart,
  input wire logic [31:0] i_ctl,
  // Injection
  output logic o_inject,
  output elsr_pkg::elsr_inj_e o_kind,
  output logic o_running,
  output logic [CNT_W-1:0] o_count
);

  typedef struct packed {
    logic running;
    logic [CNT_W-1:0] count;
    logic inject;
    elsr_pkg::elsr_inj_e kind;
  } elsr_cnt_s;

  elsr_cnt_s st_reg;
  elsr_cnt_s st_next;
  elsr_pkg::elsr_inj_e pick;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed priority, most severe enabled kind wins
  always_comb begin
    pick = elsr_pkg::ELSR_INJ_NONE;
    if (i_ctl[elsr_pkg::CTL_UC]) begin
      pick = elsr_pkg::ELSR_INJ_UC;
    end else if (i_ctl[elsr_pkg::CTL_UEU]) begin
      pick = elsr_pkg::ELSR_INJ_UEU;
    end else if (i_ctl[elsr_pkg::CTL_UER]) begin
      pick = elsr_pkg::ELSR_INJ_UER;
    end else if (i_ctl[elsr_pkg::CTL_UEO]) begin
      pick = elsr_pkg::ELSR_INJ_UEO;
    end else if (i_ctl[elsr_pkg::CTL_DE]) begin
      pick = elsr_pkg::ELSR_INJ_DE;
    end else if (i_ctl[elsr_pkg::CTL_CE_LSB+1 -: 2] != 2'h0) begin
      pick = elsr_pkg::ELSR_INJ_CE;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.inject = 1'b0;
    st_next.kind = elsr_pkg::ELSR_INJ_NONE;
    if (i_load) begin
      st_next.running = 1'b1; // R12
      st_next.count = i_value; // R12
    end else if (i_stop) begin
      st_next.running = 1'b0;
    end else if (st_reg.running) begin
      if (st_reg.count == '0) begin
        // Nothing fires when no kind is enabled
        st_next.inject = (pick != elsr_pkg::ELSR_INJ_NONE); // R11
        st_next.kind = pick; // R11
        st_next.running = i_restart;
        st_next.count = i_value;
      end else begin
        st_next.count = st_reg.count - 1'b1; // R12
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_inject = st_reg.inject;
  assign o_kind = st_reg.kind;
  assign o_running = st_reg.running;
  assign o_count = st_reg.count;

endmodule

`default_nettype wire

// ===== tb/elsr_record_sva.sv
/*
  Checker for the error record: read timing, view gating, capture codes,
  countdown start and stop. Assumes it is bound onto every elsr_record.
*/
`default_nettype none

module elsr_record_sva #(
  parameter int L2_SIZE_LOG2 = 2
) (
  // Clock, reset and capture
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_err_valid,
  input wire elsr_pkg::elsr_src_e i_err_src,
  input wire logic [1:0] i_err_array,
  // Register access
  input wire logic i_sreg_rd,
  input wire logic i_sreg_wr,
  input wire elsr_pkg::elsr_id_e i_sreg_id,
  input wire logic [63:0] i_sreg_wdata,
  input wire logic [63:0] o_sreg_rdata,
  input wire logic o_sreg_rvalid,
  // Injection
  input wire logic o_inject,
  input wire elsr_pkg::elsr_inj_e o_inject_kind,
  input wire logic o_countdown_running
);
  logic [15:0] sel_reg;
  logic [3:0] unit_reg;
  // Shadow of the selector, since only ports are visible here
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sel_reg <= 16'h0;
      unit_reg <= 4'h0;
    end else begin
      if (i_sreg_wr && i_sreg_id == elsr_pkg::ELSR_ID_SELECTOR) sel_reg <= i_sreg_wdata[15:0];
      if (i_err_valid) unit_reg <= (i_err_src == elsr_pkg::ELSR_SRC_L1I) ? 4'h1 :
        ((i_err_src == elsr_pkg::ELSR_SRC_L1D) ? 4'h4 : 4'h8);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_rd_syn;
    i_sreg_rd && !i_sreg_wr && !i_err_valid && sel_reg == 16'h0 &&
      i_sreg_id == elsr_pkg::ELSR_ID_SYN_VIEW;
  endsequence
  sequence s_l2d;
    i_err_valid && i_err_src == elsr_pkg::ELSR_SRC_L2 && i_err_array == 2'h1;
  endsequence
  property p_rvalid; o_sreg_rvalid == $past(i_sreg_rd); endproperty
  property p_hold; !i_sreg_rd |=> $stable(o_sreg_rdata); endproperty
  property p_spare;
    i_sreg_rd && i_sreg_id == elsr_pkg::ELSR_ID_SPARE_VIEW |=> o_sreg_rdata == 64'h0;
  endproperty
  property p_gate;
    i_sreg_rd && sel_reg != 16'h0 && i_sreg_id != elsr_pkg::ELSR_ID_SELECTOR
      |=> o_sreg_rdata == 64'h0;
  endproperty
  property p_kind; o_inject == (o_inject_kind != elsr_pkg::ELSR_INJ_NONE); endproperty
  property p_unit; i_err_valid ##1 s_rd_syn |=> o_sreg_rdata[3:0] == unit_reg; endproperty
  property p_l2d;
    s_l2d ##1 s_rd_syn |=> o_sreg_rdata[18:L2_SIZE_LOG2+9] == '0 && o_sreg_rdata[5:4] == 2'h1;
  endproperty
  property p_start;
    i_sreg_wr && i_sreg_id == elsr_pkg::ELSR_ID_CTL_VIEW && sel_reg == 16'h0
      |=> o_countdown_running == $past(i_sreg_wdata[31]);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid not one cycle after read");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_spare: assert property (p_spare) else $error("spare view not zero");
  a_gate: assert property (p_gate) else $error("view open with selector set");
  a_kind: assert property (p_kind) else $error("kind and inject disagree");
  a_unit: assert property (p_unit) else $error("unit code wrong");
  a_l2d: assert property (p_l2d) else $error("level 2 data index not masked");
  a_start: assert property (p_start) else $error("countdown enable not followed");
endmodule

bind elsr_record elsr_record_sva #(.L2_SIZE_LOG2(L2_SIZE_LOG2)) elsr_record_sva_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_err_valid(i_err_valid), .i_err_src(i_err_src),
  .i_err_array(i_err_array), .i_sreg_rd(i_sreg_rd), .i_sreg_wr(i_sreg_wr),
  .i_sreg_id(i_sreg_id), .i_sreg_wdata(i_sreg_wdata), .o_sreg_rdata(o_sreg_rdata),
  .o_sreg_rvalid(o_sreg_rvalid), .o_inject(o_inject), .o_inject_kind(o_inject_kind),
  .o_countdown_running(o_countdown_running));

`default_nettype wire

// ===== tb/test_error_location_syndrome_record.sv
/*
  Bench for the error record: captures, register views and the countdown.
  Assumes the package, design and checker are compiled before it.
*/
`default_nettype none

module test_error_location_syndrome_record;
  timeunit 1ns;
  timeprecision 1ns;
  // Wider than the queue mask so the two index cases differ
  localparam int L2S = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ev = 1'b0;
  elsr_pkg::elsr_src_e src = elsr_pkg::ELSR_SRC_L1I;
  logic [1:0] arr = 2'h0;
  logic [2:0] fl = 3'h1;
  logic [12:0] idx = 13'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  elsr_pkg::elsr_id_e id = elsr_pkg::ELSR_ID_SELECTOR;
  logic [63:0] wd = 64'h0;
  logic [63:0] rdata;
  logic rvalid;
  logic inj;
  elsr_pkg::elsr_inj_e kind;
  logic run;
  logic [63:0] rv;
  logic [63:0] sv;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int k;

  elsr_record #(.L2_SIZE_LOG2(L2S)) elsr_record_i (
    .i_clk(clk), .i_srst(srst), .i_err_valid(ev), .i_err_src(src), .i_err_array(arr),
    .i_err_l1i_fail(fl), .i_err_index(idx), .i_sreg_rd(rd), .i_sreg_wr(wr), .i_sreg_id(id),
    .i_sreg_wdata(wd), .o_sreg_rdata(rdata), .o_sreg_rvalid(rvalid), .o_inject(inj),
    .o_inject_kind(kind), .o_countdown_running(run));

  initial begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [18:0] exp_loc(elsr_pkg::elsr_src_e s, logic [1:0] a,
                                          logic [2:0] f, logic [12:0] x);
    logic [3:0] u;
    logic [1:0] ar;
    logic [12:0] ix;
    u = 4'h8;
    ar = a;
    ix = x;
    if (s == elsr_pkg::ELSR_SRC_L1I) begin
      u = 4'h1;
      ar = f[1] ? 2'h1 : (f[0] ? 2'h0 : 2'h2);
    end else if (s == elsr_pkg::ELSR_SRC_L1D) u = 4'h4;
    else if (a == 2'h1) ix = x & ((13'h1 << (L2S + 3)) - 13'h1);
    else if (a == 2'h2) ix = x & 13'h001f;
    else if (a == 2'h3) ix = 13'h0;
    return {ix, ar, u};
  endfunction

  function automatic elsr_pkg::elsr_inj_e exp_kind(logic [31:0] c);
    if (c[1]) return elsr_pkg::ELSR_INJ_UC;
    if (c[2]) return elsr_pkg::ELSR_INJ_UEU;
    if (c[3]) return elsr_pkg::ELSR_INJ_UER;
    if (c[4]) return elsr_pkg::ELSR_INJ_UEO;
    if (c[5]) return elsr_pkg::ELSR_INJ_DE;
    if (c[7:6] != 2'h0) return elsr_pkg::ELSR_INJ_CE;
    return elsr_pkg::ELSR_INJ_NONE;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic r, input logic w, input elsr_pkg::elsr_id_e a,
                     input logic [63:0] d);
    @(negedge clk);
    rd = r;
    wr = w;
    id = a;
    wd = d;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    rv = rdata;
    if (r) chk("rvalid", 64'(rvalid), 64'h1);
  endtask

  task automatic rdchk(input elsr_pkg::elsr_id_e a, input logic [63:0] exp);
    acc(1'b1, 1'b0, a, 64'h0);
    chk(a.name(), rv, exp);
  endtask

  task automatic cap(input elsr_pkg::elsr_src_e s, input logic [1:0] a, input logic [2:0] f,
                     input logic [12:0] x);
    @(negedge clk);
    ev = 1'b1;
    src = s;
    arr = a;
    fl = f;
    idx = x;
    @(negedge clk);
    ev = 1'b0;
    rdchk(elsr_pkg::ELSR_ID_SYN_VIEW, {45'h0, exp_loc(s, a, f, x)});
  endtask

  // Counts edges until the next injection pulse
  task automatic wait_inj(input int w, input logic [31:0] c);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (inj !== 1'b1 && k < 40);
    chk("delay", 64'(k), 64'(w));
    chk("kind", 64'(kind), 64'(exp_kind(c)));
  endtask

  task automatic cdn(input logic [31:0] n, input logic [31:0] c);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_CDN_VIEW, {32'h0, n});
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_CTL_VIEW, {32'h0, c});
    chk("running", 64'(run), 64'h1);
    // Load edge sets count n; zero seen n edges later, pulse on the next
    wait_inj(n + 1, c);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hd311));
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rdchk(elsr_pkg::ELSR_ID_SYN_VIEW, 64'h0);
    cap(elsr_pkg::ELSR_SRC_L1I, 2'h3, 3'h7, 13'h1fff);
    cap(elsr_pkg::ELSR_SRC_L1I, 2'h1, 3'h5, 13'h0aaa);
    for (int a = 1; a < 4; a++) cap(elsr_pkg::ELSR_SRC_L2, 2'(a), 3'h1, 13'h1fff);
    for (int j = 0; j < 60; j++)
      cap(elsr_pkg::elsr_src_e'($urandom_range(2, 0)), 2'($urandom_range(3, 0)),
          3'($urandom_range(7, 1)), 13'($urandom));
    sv = {$urandom, $urandom};
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_SYN_VIEW, sv);
    rdchk(elsr_pkg::ELSR_ID_SYN_VIEW, sv);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_SELECTOR, 64'h5);
    rdchk(elsr_pkg::ELSR_ID_SYN_VIEW, 64'h0);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_SYN_VIEW, 64'h0);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_CTL_VIEW, 64'h8000_0002);
    chk("gated start", 64'(run), 64'h0);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_SELECTOR, 64'h0);
    rdchk(elsr_pkg::ELSR_ID_SYN_VIEW, sv);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_SPARE_VIEW, '1);
    rdchk(elsr_pkg::ELSR_ID_SPARE_VIEW, 64'h0);
    for (int j = 0; j < 7; j++)
      cdn($urandom_range(5, 0), 32'h8000_0000 | ((j < 5) ? (32'h2 << j) :
          ((j == 5) ? 32'h40 : 32'h3e)));
    cdn(32'h3, 32'hc000_0004);
    wait_inj(4, 32'h4);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_CTL_VIEW, '1);
    rdchk(elsr_pkg::ELSR_ID_CTL_VIEW, 64'hc000_1fff);
    acc(1'b0, 1'b1, elsr_pkg::ELSR_ID_CTL_VIEW, 64'h0);
    chk("stopped", 64'(run), 64'h0);
    close_out();
  end
endmodule

`default_nettype wire
